// file: asl_consts.svh
`ifndef ASL_CONSTS_SVH
`define ASL_CONSTS_SVH
// ----------------------------------------
// Register offsets and reset values
// ----------------------------------------
`define ASL_ADDR_INACT   8'h29
`define ASL_ADDR_CTRL1   8'h2a
`define ASL_ADDR_CTRL2   8'h2b
`define ASL_INACT_RST    8'h00
`define ASL_CTRL1_RST    8'h00
`define ASL_CTRL2_RST    8'h00
// ----------------------------------------
// Field positions
// ----------------------------------------
`define ASL_C1_SRATE_HI  7
`define ASL_C1_SRATE_LO  6
`define ASL_C1_ARATE_HI  5
`define ASL_C1_ARATE_LO  3
`define ASL_C1_LOW_NOISE_SEL    2
`define ASL_C1_FREAD     1
`define ASL_C1_ACTIVE    0
`define ASL_C2_SELFTEST  7
`define ASL_C2_SWRST     6
`define ASL_C2_SLEEP_OVERSAMPLE_SEL_HI  4
`define ASL_C2_SLEEP_OVERSAMPLE_SEL_LO  3
`define ASL_C2_AUTO_SLEEP_EN      2
`define ASL_C2_WAKE_OVERSAMPLE_SEL_HI   1
`define ASL_C2_WAKE_OVERSAMPLE_SEL_LO   0
// ----------------------------------------
// Rates, read pointer, timing
// ----------------------------------------
`define ASL_SLEEP_RATE_BASE 3'h4
`define ASL_RATE_SLOWEST    3'h7
`define ASL_DATA_FIRST      8'h01
`define ASL_DATA_LAST       8'h06
`define ASL_UNIT_MS         320
`define ASL_CLK_MHZ         100
`define ASL_UNIT_CYCLES     (`ASL_UNIT_MS * 1000 * `ASL_CLK_MHZ)
`define ASL_BOOT_CYCLES     4'h8
`endif

// file: asl_pkg.sv
package asl_pkg;
  typedef enum logic [2:0]
  {
    st_standby = 3'b001,
    st_wake    = 3'b010,
    st_sleep   = 3'b100
  } asl_state_t;

  typedef enum logic [1:0]
  {
    osr_normal  = 2'b00,
    osr_lnlp    = 2'b01,
    osr_hires   = 2'b10,
    osr_lowpow  = 2'b11
  } asl_osr_t;
endpackage

// file: asl_mode_ctrl.sv
`timescale 1ns/10ps
`include "asl_consts.svh"
// Function
// - Auto-sleep drops to sleep rate after inactivity reaches inactivity_count units.
// - Count unit is 320 ms, or 640 ms at the 1.56 Hz rate.
// - Transient, orientation, tap, fall/motion events restart timer and can wake.
// - Sleep/wake and sample-ready events never restart timer nor wake.
// - Wake only when function interrupt enabled and selected as wake source.
// - Enabled functions keep running at sleep rate; unselected ones never wake.
// - In sleep the sleep rate overrides output and function rates.
// - Without auto-sleep, only standby and wake states are used.
// - With its interrupt enabled, each wake/sleep transition raises an event.
// - Sleep rate code 00..11 selects 50, 12.5, 6.25, 1.56 Hz; reset 00.
// - Active rate code 000..111 selects 800 down to 1.56 Hz; reset 000.
// - Active bit 0 is standby (reset), 1 is active.
// - Low-noise bit limits range to 4 g.
// - Fast-read makes read auto-increment skip low data bytes.
// - Self-test bit activates self-test, shifting axis outputs.
// - Writing 1 to software reset reloads every register default immediately.
// - Software reset also resets serial bus interface logic.
// - Software reset bit self-clears after boot and always reads 0.
// - Separate wake and sleep oversampling fields, 00/01/10/11 decoded as modes.
// - Averaging ratio follows oversampling mode and current rate.
// - Wake-select 0 excludes a function from waking; 1 allows it.
// - Interrupt enables gate event flags to the interrupt controller.
module asl_mode_ctrl
#(
  parameter int UNIT_CYCLES = `ASL_UNIT_CYCLES
)
(
  input  wire logic             clock,
  input  wire logic             rst_b,
  input  wire logic [7:0]       reg_addr,
  input  wire logic [7:0]       reg_wdata,
  input  wire logic             reg_wr,
  input  wire logic             reg_rd,
  output logic [7:0]            reg_rdata,
  output logic [7:0]            read_next_addr,
  output logic                  bus_reset,
  input  wire logic             transient_event,
  input  wire logic             orientation_event,
  input  wire logic             tap_event,
  input  wire logic             fall_motion_event,
  input  wire logic             sample_ready_event,
  input  wire logic [3:0]       wake_sel,
  input  wire logic [3:0]       func_irq_en,
  input  wire logic             sleep_wake_irq_en,
  input  wire logic             sample_ready_irq_en,
  output logic [5:0]            irq_flags,
  output logic                  sleep_wake_event,
  output asl_pkg::asl_state_t   mode_state,
  output logic [2:0]            eff_rate_sel,
  output asl_pkg::asl_osr_t     eff_oversample_sel,
  output logic [10:0]           os_ratio,
  output logic                  low_noise_sel,
  output logic                  range_limit_4g,
  output logic                  self_test_en
);
  import asl_pkg::*;
  // ----------------------------------------
  // Decode functions
  // ----------------------------------------
  function automatic logic [10:0] ratio_of(input asl_osr_t m, input logic [2:0] r);
    logic [10:0] v;
    v = 11'h002;
    case (m)
      osr_normal:
        case (r)
          3'h7:    v = 11'h080;
          3'h6:    v = 11'h020;
          3'h5:    v = 11'h010;
          3'h0:    v = 11'h002;
          default: v = 11'h004;
        endcase
      osr_lnlp:
        case (r)
          3'h7:    v = 11'h020;
          3'h6:    v = 11'h008;
          3'h0:    v = 11'h002;
          default: v = 11'h004;
        endcase
      osr_hires:
        case (r)
          3'h7:    v = 11'h400;
          3'h6:    v = 11'h100;
          3'h5:    v = 11'h080;
          3'h4:    v = 11'h020;
          3'h3:    v = 11'h010;
          3'h2:    v = 11'h008;
          3'h1:    v = 11'h004;
          default: v = 11'h002;
        endcase
      osr_lowpow:
        case (r)
          3'h7:    v = 11'h010;
          3'h6:    v = 11'h004;
          default: v = 11'h002;
        endcase
      default: v = 11'h002;
    endcase
    return v;
  endfunction
  function automatic logic [7:0] next_addr(input logic [7:0] a, input logic fast);
    logic [7:0] n;
    n = a + 8'h01;
    if (fast && a >= `ASL_DATA_FIRST && a < `ASL_DATA_LAST)
      n = a + 8'h02;
    return n;
  endfunction
  // ----------------------------------------
  // Registers and soft reset
  // ----------------------------------------
  logic [7:0]  inactivity_count;
  logic [7:0]  system_control_one;
  logic [4:0]  ctrl_two_bits;
  logic        self_test_bit;
  logic [3:0]  boot_cnt;
  logic        booting;
  logic        wr_inact;
  logic        wr_ctrl1;
  logic        wr_ctrl2;
  logic        soft_rst_req;
  assign booting      = (boot_cnt != 4'h0);
  assign wr_inact     = reg_wr && !booting && reg_addr == `ASL_ADDR_INACT;
  assign wr_ctrl1     = reg_wr && !booting && reg_addr == `ASL_ADDR_CTRL1;
  assign wr_ctrl2     = reg_wr && !booting && reg_addr == `ASL_ADDR_CTRL2;
  assign soft_rst_req = wr_ctrl2 && reg_wdata[`ASL_C2_SWRST];
  assign bus_reset    = booting;
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      boot_cnt <= 4'h0;
    else if (soft_rst_req)
      boot_cnt <= `ASL_BOOT_CYCLES;
    else if (booting)
      boot_cnt <= boot_cnt - 4'h1;
  end
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      inactivity_count <= `ASL_INACT_RST;
    else if (booting || soft_rst_req)
      inactivity_count <= `ASL_INACT_RST;
    else if (wr_inact)
      inactivity_count <= reg_wdata;
  end
  // Host keeps the standby discipline; fields are taken as written
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      system_control_one <= `ASL_CTRL1_RST;
    else if (booting || soft_rst_req)
      system_control_one <= `ASL_CTRL1_RST;
    else if (wr_ctrl1)
      system_control_one <= reg_wdata;
  end
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      self_test_bit <= 1'b0;
      ctrl_two_bits <= 5'h00;
    end
    else if (booting || soft_rst_req)
    begin
      self_test_bit <= 1'(`ASL_CTRL2_RST >> `ASL_C2_SELFTEST);
      ctrl_two_bits <= 5'h00;
    end
    else if (wr_ctrl2)
    begin
      self_test_bit <= reg_wdata[`ASL_C2_SELFTEST];
      ctrl_two_bits <= reg_wdata[`ASL_C2_SLEEP_OVERSAMPLE_SEL_HI:`ASL_C2_WAKE_OVERSAMPLE_SEL_LO];
    end
  end
  logic [1:0]  sleep_rate_sel;
  logic [2:0]  active_rate_sel;
  logic        fast_read_sel;
  logic        active_sel;
  logic        auto_sleep_en;
  asl_osr_t    wake_oversample_sel;
  asl_osr_t    sleep_oversample_sel;
  assign sleep_rate_sel       = system_control_one[`ASL_C1_SRATE_HI:`ASL_C1_SRATE_LO];
  assign active_rate_sel      = system_control_one[`ASL_C1_ARATE_HI:`ASL_C1_ARATE_LO];
  assign fast_read_sel        = system_control_one[`ASL_C1_FREAD];
  assign active_sel           = system_control_one[`ASL_C1_ACTIVE];
  assign auto_sleep_en        = ctrl_two_bits[`ASL_C2_AUTO_SLEEP_EN];
  assign wake_oversample_sel  = asl_osr_t'(ctrl_two_bits[`ASL_C2_WAKE_OVERSAMPLE_SEL_HI:`ASL_C2_WAKE_OVERSAMPLE_SEL_LO]);
  assign sleep_oversample_sel = asl_osr_t'(ctrl_two_bits[`ASL_C2_SLEEP_OVERSAMPLE_SEL_HI:`ASL_C2_SLEEP_OVERSAMPLE_SEL_LO]);
  // ----------------------------------------
  // Register reads
  // ----------------------------------------
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      reg_rdata      <= 8'h00;
      read_next_addr <= 8'h00;
    end
    else if (reg_rd)
    begin
      case (reg_addr)
        `ASL_ADDR_INACT: reg_rdata <= inactivity_count;
        `ASL_ADDR_CTRL1: reg_rdata <= system_control_one;
        `ASL_ADDR_CTRL2: reg_rdata <= {self_test_bit, 2'b00, ctrl_two_bits};
        default:         reg_rdata <= 8'h00;
      endcase
      read_next_addr <= next_addr(reg_addr, fast_read_sel);
    end
  end
  // ----------------------------------------
  // Inactivity timer
  // ----------------------------------------
  asl_state_t  state;
  asl_state_t  next_state;
  logic [31:0] tick_cnt;
  logic        half_unit;
  logic [7:0]  units;
  logic        restart;
  logic        wake_hit;
  logic        go_sleep;
  logic [3:0]  det_events;
  assign det_events = {transient_event, orientation_event, tap_event, fall_motion_event};
  // Sleep/wake and sample-ready events are kept out on purpose
  assign restart  = |det_events;
  assign wake_hit = |(det_events & func_irq_en & wake_sel);
  assign go_sleep = auto_sleep_en && !restart && units >= inactivity_count;
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      tick_cnt  <= 32'h0;
      half_unit <= 1'b0;
      units     <= 8'h00;
    end
    else if (state != st_wake || !auto_sleep_en || restart || booting)
    begin
      tick_cnt  <= 32'h0;
      half_unit <= 1'b0;
      units     <= 8'h00;
    end
    else if (tick_cnt == 32'(UNIT_CYCLES - 1))
    begin
      tick_cnt <= 32'h0;
      // Slowest rate needs two base units per count step
      if (active_rate_sel == `ASL_RATE_SLOWEST && !half_unit)
        half_unit <= 1'b1;
      else
      begin
        half_unit <= 1'b0;
        if (units != 8'hff)
          units <= units + 8'h01;
      end
    end
    else
      tick_cnt <= tick_cnt + 32'h1;
  end

  // ----------------------------------------
  // Mode state machine
  // ----------------------------------------
  always_comb
  begin
    next_state = state;
    case (state)
      st_standby:
        if (active_sel)
          next_state = st_wake;
      st_wake:
        if (!active_sel)
          next_state = st_standby;
        else if (go_sleep)
          next_state = st_sleep;
      st_sleep:
        if (!active_sel)
          next_state = st_standby;
        else if (!auto_sleep_en || wake_hit)
          next_state = st_wake;
      default:
        next_state = st_standby;
    endcase
  end

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      state <= st_standby;
    else if (booting || soft_rst_req)
      state <= st_standby;
    else
      state <= next_state;
  end

  assign mode_state = state;

  // ----------------------------------------
  // Events toward the interrupt controller
  // ----------------------------------------
  logic trans_evt;
  assign trans_evt = !booting && !soft_rst_req &&
                     ((state == st_wake && next_state == st_sleep) ||
                      (state == st_sleep && next_state == st_wake));
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      sleep_wake_event <= 1'b0;
    else
      sleep_wake_event <= trans_evt && sleep_wake_irq_en;
  end

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      irq_flags <= 6'h00;
    else
      irq_flags <= {trans_evt && sleep_wake_irq_en,
                    det_events & func_irq_en,
                    sample_ready_event && sample_ready_irq_en};
  end

  // ----------------------------------------
  // Effective rate and oversampling
  // ----------------------------------------
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      eff_rate_sel       <= 3'h0;
      eff_oversample_sel <= osr_normal;
      os_ratio           <= 11'h002;
    end
    else if (state == st_sleep)
    begin
      // Sleep code maps onto the four slowest active codes
      eff_rate_sel       <= `ASL_SLEEP_RATE_BASE + {1'b0, sleep_rate_sel};
      eff_oversample_sel <= sleep_oversample_sel;
      os_ratio           <= ratio_of(sleep_oversample_sel,
                                     `ASL_SLEEP_RATE_BASE + {1'b0, sleep_rate_sel});
    end
    else
    begin
      eff_rate_sel       <= active_rate_sel;
      eff_oversample_sel <= wake_oversample_sel;
      os_ratio           <= ratio_of(wake_oversample_sel, active_rate_sel);
    end
  end

  // ----------------------------------------
  // Analog side controls
  // ----------------------------------------
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      low_noise_sel  <= 1'b0;
      range_limit_4g <= 1'b0;
      self_test_en   <= 1'b0;
    end
    else
    begin
      low_noise_sel  <= system_control_one[`ASL_C1_LOW_NOISE_SEL];
      range_limit_4g <= system_control_one[`ASL_C1_LOW_NOISE_SEL];
      self_test_en   <= self_test_bit;
    end
  end
endmodule

// file: asl_mode_sva.sv
`timescale 1ns/10ps
// ------------------------------
// Mode checker
// ------------------------------
module asl_mode_sva
#(
  parameter int UNIT_CYCLES = 10
)
(
  input wire logic       clock,
  input wire logic       rst_b,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       bus_reset,
  input wire logic       transient_event,
  input wire logic       orientation_event,
  input wire logic       tap_event,
  input wire logic       fall_motion_event,
  input wire logic       sample_ready_event,
  input wire logic [3:0] wake_sel,
  input wire logic [3:0] func_irq_en,
  input wire logic       sleep_wake_irq_en,
  input wire logic       sample_ready_irq_en,
  input wire logic [5:0] irq_flags,
  input wire logic       sleep_wake_event,
  input wire asl_pkg::asl_state_t mode_state,
  input wire logic [2:0] eff_rate_sel,
  input wire logic [10:0] os_ratio
);
  import asl_pkg::*;
  logic [3:0] qual;
  assign qual = {transient_event, orientation_event, tap_event, fall_motion_event}
    & wake_sel & func_irq_en;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);
  sequence s_boot;
    bus_reset [*8] ##1 !bus_reset;
  endsequence
  a_rst_bit_zero: assert property (reg_rd && reg_addr == 8'h2b |=> reg_rdata[6:5] == 2'h0)
    else $error("reset bit read nonzero");
  a_boot_bus_reset: assert property (reg_wr && reg_addr == 8'h2b && reg_wdata[6] && !bus_reset
    |=> s_boot)
    else $error("bus reset length wrong");
  a_wake_qualified: assert property (mode_state == st_sleep && |qual && !bus_reset
    |-> ##[1:2] mode_state == st_wake)
    else $error("qualified event did not wake");
  a_no_wake_unqual: assert property (mode_state == st_sleep && !(|qual) && !reg_wr
    && !$past(reg_wr) |=> mode_state != st_wake)
    else $error("woke without qualified event");
  a_sleep_edge_event: assert property (mode_state == st_sleep && $past(mode_state) == st_wake
    && sleep_wake_irq_en |-> ##[0:1] sleep_wake_event)
    else $error("no sleep event");
  a_event_one_cycle: assert property (sleep_wake_event |=> !sleep_wake_event)
    else $error("sleep event too long");
  a_irq_gate_off: assert property (sample_ready_event && !sample_ready_irq_en
    |=> !irq_flags[0])
    else $error("disabled flag passed");
  a_irq_gate_on: assert property (transient_event && func_irq_en[3] |=> irq_flags[4])
    else $error("enabled flag lost");
  a_sleep_rate_hi: assert property (mode_state == st_sleep [*2] |-> eff_rate_sel[2])
    else $error("sleep rate not applied");
  a_fast_ratio: assert property (eff_rate_sel == 3'h0 [*3] |-> os_ratio == 11'h002)
    else $error("ratio at fastest rate wrong");
endmodule
bind asl_mode_ctrl asl_mode_sva #(.UNIT_CYCLES(UNIT_CYCLES)) asl_mode_sva_i
(
  .clock               (clock),
  .rst_b               (rst_b),
  .reg_addr            (reg_addr),
  .reg_wdata           (reg_wdata),
  .reg_wr              (reg_wr),
  .reg_rd              (reg_rd),
  .reg_rdata           (reg_rdata),
  .bus_reset           (bus_reset),
  .transient_event     (transient_event),
  .orientation_event   (orientation_event),
  .tap_event           (tap_event),
  .fall_motion_event   (fall_motion_event),
  .sample_ready_event  (sample_ready_event),
  .wake_sel            (wake_sel),
  .func_irq_en         (func_irq_en),
  .sleep_wake_irq_en   (sleep_wake_irq_en),
  .sample_ready_irq_en (sample_ready_irq_en),
  .irq_flags           (irq_flags),
  .sleep_wake_event    (sleep_wake_event),
  .mode_state          (mode_state),
  .eff_rate_sel        (eff_rate_sel),
  .os_ratio            (os_ratio)
);

// file: asl_host_model.sv
`timescale 1ns/10ps
`include "asl_consts.svh"
// ------------------------------
// Host side of the register bus
// ------------------------------
module asl_host_model
(
  input  wire logic       clock,
  input  wire logic [7:0] reg_rdata,
  output logic      [7:0] reg_addr,
  output logic      [7:0] reg_wdata,
  output logic            reg_wr,
  output logic            reg_rd
);
  logic [7:0] ctrl1_shadow = 8'h00;
  initial
  begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
  end
  task automatic put(input logic [7:0] a, input logic [7:0] d, input logic w);
    @(negedge clock);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = w;
    reg_rd = !w;
    @(negedge clock);
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    // Idle bus never shows the last value
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    if (a == `ASL_ADDR_CTRL1 && ctrl1_shadow[0] && d[7:1] != ctrl1_shadow[7:1])
      put(a, {ctrl1_shadow[7:1], 1'b0}, 1'b1);
    if (a == `ASL_ADDR_CTRL1)
      ctrl1_shadow = d;
    // Soft reset puts control one back to standby defaults
    if (a == `ASL_ADDR_CTRL2 && d[`ASL_C2_SWRST])
      ctrl1_shadow = 8'h00;
    put(a, d, 1'b1);
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    put(a, 8'h00, 1'b0);
    d = reg_rdata;
  endtask
endmodule

// file: asl_mode_ctrl_bench.sv
`timescale 1ns/10ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin fails++; \
  $display("[FAIL] %0t %h %h", $time, a, b); end end
// ------------------------------
// Bench
// ------------------------------
module asl_mode_ctrl_bench;
  import asl_pkg::*;
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, read_next_addr, d;
  logic reg_wr, reg_rd, bus_reset, sleep_wake_event, saw_ev;
  logic [4:0] ev = 5'h00;
  wire transient_event, orientation_event, tap_event, fall_motion_event, sample_ready_event;
  logic [3:0] wake_sel = 4'h0;
  logic [3:0] func_irq_en = 4'h0;
  logic sleep_wake_irq_en = 1'b1;
  logic sample_ready_irq_en = 1'b0;
  logic [5:0] irq_flags;
  asl_state_t mode_state;
  logic [2:0] eff_rate_sel;
  asl_osr_t eff_oversample_sel;
  logic [10:0] os_ratio;
  logic low_noise_sel, range_limit_4g, self_test_en;
  int fails = 0;
  int checked = 0;
  int cycles = 0;
  int n;
  logic [7:0] chk_addr [4] = '{8'h29, 8'h2a, 8'h2b, 8'h2c};
  assign {transient_event, orientation_event, tap_event, fall_motion_event,
    sample_ready_event} = ev;
  asl_mode_ctrl #(.UNIT_CYCLES(10)) asl_mode_ctrl_i
  (
    .clock               (clock),
    .rst_b               (rst_b),
    .reg_addr            (reg_addr),
    .reg_wdata           (reg_wdata),
    .reg_wr              (reg_wr),
    .reg_rd              (reg_rd),
    .reg_rdata           (reg_rdata),
    .read_next_addr      (read_next_addr),
    .bus_reset           (bus_reset),
    .transient_event     (transient_event),
    .orientation_event   (orientation_event),
    .tap_event           (tap_event),
    .fall_motion_event   (fall_motion_event),
    .sample_ready_event  (sample_ready_event),
    .wake_sel            (wake_sel),
    .func_irq_en         (func_irq_en),
    .sleep_wake_irq_en   (sleep_wake_irq_en),
    .sample_ready_irq_en (sample_ready_irq_en),
    .irq_flags           (irq_flags),
    .sleep_wake_event    (sleep_wake_event),
    .mode_state          (mode_state),
    .eff_rate_sel        (eff_rate_sel),
    .eff_oversample_sel  (eff_oversample_sel),
    .os_ratio            (os_ratio),
    .low_noise_sel       (low_noise_sel),
    .range_limit_4g      (range_limit_4g),
    .self_test_en        (self_test_en)
  );
  asl_host_model asl_host_model_i
  (
    .clock     (clock),
    .reg_rdata (reg_rdata),
    .reg_addr  (reg_addr),
    .reg_wdata (reg_wdata),
    .reg_wr    (reg_wr),
    .reg_rd    (reg_rd)
  );
  initial
  begin
    forever #5 clock = ~clock;
  end
  // Sleep event is one cycle wide, so latch it
  always @(posedge clock)
  begin
    cycles++;
    if (sleep_wake_event === 1'b1)
      saw_ev = 1'b1;
    if (cycles == 3000)
    begin
      fails++;
      print_verdict();
    end
  end
  task automatic print_verdict();
    if (fails == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic pulse(input logic [4:0] e);
    @(negedge clock);
    ev = e;
    @(negedge clock);
    ev = 5'h00;
  endtask
  initial
  begin
    saw_ev = 1'b0;
    repeat (3) @(negedge clock);
    rst_b = 1'b1;
    asl_host_model_i.wr(8'h2c, 8'hff);
    foreach (chk_addr[i])
    begin
      asl_host_model_i.rd(chk_addr[i], d);
      `CHK(d, 8'h00)
    end
    `CHK(mode_state, st_standby)
    asl_host_model_i.wr(8'h29, 8'h02);
    asl_host_model_i.wr(8'h2b, 8'h1e);
    asl_host_model_i.rd(8'h2b, d);
    `CHK(d, 8'h1e)
    asl_host_model_i.wr(8'h2a, 8'hc1);
    @(negedge clock);
    `CHK(mode_state, st_wake)
    repeat (15) @(negedge clock);
    pulse(5'h10);
    n = 0;
    while (mode_state !== st_sleep && n < 200)
    begin
      @(negedge clock);
      n++;
    end
    `CHK(n >= 18 && n < 40, 1'b1)
    repeat (3) @(negedge clock);
    `CHK(eff_rate_sel, 3'h7)
    `CHK(eff_oversample_sel, osr_lowpow)
    `CHK(os_ratio, 11'h010)
    `CHK(saw_ev, 1'b1)
    pulse(5'h1f);
    `CHK(irq_flags, 6'h00)
    repeat (4) @(negedge clock);
    `CHK(mode_state, st_sleep)
    wake_sel = 4'h8;
    func_irq_en = 4'h8;
    pulse(5'h10);
    `CHK(irq_flags, 6'h30)
    repeat (4) @(negedge clock);
    `CHK(mode_state, st_wake)
    `CHK(eff_rate_sel, 3'h0)
    `CHK(eff_oversample_sel, osr_hires)
    `CHK(os_ratio, 11'h002)
    asl_host_model_i.wr(8'h2b, 8'h1a);
    repeat (60) @(negedge clock);
    `CHK(mode_state, st_wake)
    asl_host_model_i.wr(8'h2a, 8'h07);
    asl_host_model_i.rd(8'h01, d);
    `CHK(read_next_addr, 8'h03)
    asl_host_model_i.rd(8'h29, d);
    `CHK(read_next_addr, 8'h2a)
    asl_host_model_i.wr(8'h2b, 8'h80);
    repeat (2) @(negedge clock);
    `CHK({low_noise_sel, range_limit_4g}, 2'h3)
    `CHK(self_test_en, 1'b1)
    asl_host_model_i.wr(8'h2b, 8'h40);
    `CHK(bus_reset, 1'b1)
    asl_host_model_i.wr(8'h29, 8'h55);
    repeat (10) @(negedge clock);
    foreach (chk_addr[i])
    begin
      asl_host_model_i.rd(chk_addr[i], d);
      `CHK(d, 8'h00)
    end
    `CHK({mode_state, self_test_en}, {st_standby, 1'b0})
    asl_host_model_i.wr(8'h29, 8'h01);
    asl_host_model_i.wr(8'h2b, 8'h04);
    asl_host_model_i.wr(8'h2a, 8'h39);
    n = 0;
    while (mode_state !== st_sleep && n < 200)
    begin
      @(negedge clock);
      n++;
    end
    `CHK(n >= 20 && n < 30, 1'b1)
    repeat (2) @(negedge clock);
    `CHK(eff_rate_sel, 3'h4)
    `CHK(os_ratio, 11'h004)
    print_verdict();
  end
endmodule
